// >>> logic/ppl_pkg.sv
// Shared constants, register map and carrier types for the phase pulse supervisor
package ppl_pkg;

  // Structure of the controller
  localparam int NPH = 12; // Phase pins
  localparam int NCH = 2; // Output channels

  // Core clock and derived timing
  localparam int CLK_HZ = 125_000_000;
  localparam int US_PER_S = 1_000_000;
  localparam int TICK_CYC = CLK_HZ / US_PER_S; // Cycles per microsecond tick
  localparam int HICCUP_MS = 25; // Default hiccup wait in milliseconds
  localparam int HICCUP_CYC_DEF = (CLK_HZ / 1000) * HICCUP_MS;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [5:0] ADDR_OPTIONS = 6'h00;
  localparam logic [5:0] ADDR_PULSE = 6'h04;
  localparam logic [5:0] ADDR_BRAKE = 6'h08;
  localparam logic [5:0] ADDR_PHASES = 6'h0C;
  localparam logic [5:0] ADDR_COUNTS = 6'h10;
  localparam logic [5:0] ADDR_RESP = 6'h14;
  localparam logic [5:0] ADDR_DELAY = 6'h18;
  localparam logic [5:0] ADDR_MASK = 6'h1C;
  localparam logic [5:0] ADDR_STATUS = 6'h20;
  localparam logic [5:0] ADDR_CLEAR = 6'h24;

  // Clear-faults page codes
  localparam logic [7:0] PAGE_ALL = 8'hFF;

  // Fault response codes
  localparam logic [1:0] RSP_IGNORE = 2'h0;
  localparam logic [1:0] RSP_LATCH = 2'h1;
  localparam logic [1:0] RSP_HYST = 2'h2;
  localparam logic [1:0] RSP_HICCUP = 2'h3;

  // Status bits per channel
  localparam int ST_W = 6;
  localparam logic [7:0] CNT8_MAX = 8'hFF;
  localparam logic [15:0] CNT16_MAX = 16'hFFFF;
  localparam logic [4:0] ALL_PHASES = 5'h1F;

  // Software options; reset value all zero
  typedef struct packed {
    logic restart_target_select; // 1: restart to boot_target
    logic trunc_en; // Cut pulses on overshoot
    logic brake_en; // Tri-state phases on overshoot
    logic [NCH-1:0] chan_on; // Channel enable commands
  } ppl_opt_t;

  // Pulse limits in clock cycles
  typedef struct packed {
    logic [7:0] blank;
    logic [7:0] min_off;
    logic [7:0] min_on;
  } ppl_pulse_t;

  // Phase counts per channel
  typedef struct packed {
    logic [NCH-1:0][3:0] level_one_phase_count;
    logic [NCH-1:0][3:0] base_count;
  } ppl_counts_t;

  // Fault responses, two bits each
  typedef struct packed {
    logic [1:0] shared_rsp;
    logic [1:0] oc_rsp;
    logic [1:0] uv_rsp;
    logic [1:0] ov_rsp;
  } ppl_rsp_t;

  // Turn-on and turn-off delays in microseconds
  typedef struct packed {
    logic [15:0] toff_us;
    logic [15:0] ton_us;
  } ppl_dly_t;

  // Detector levels from the analog side, one bit per channel except the single shared fault bit
  typedef struct packed {
    logic shared_f;
    logic [NCH-1:0] uv_w;
    logic [NCH-1:0] ov_w;
    logic [NCH-1:0] oc_f;
    logic [NCH-1:0] uv_f;
    logic [NCH-1:0] ov_f;
    logic [NCH-1:0] undershoot_level_two;
    logic [NCH-1:0] undershoot_level_one;
    logic [NCH-1:0] dyn_integ_threshold;
    logic [NCH-1:0] overshoot_threshold;
  } ppl_det_t;

  // Channel sequencer states
  typedef enum logic [2:0] {
    CH_OFF, CH_TON, CH_RUN, CH_TOFF, CH_LATCH, CH_HYST, CH_HICCUP
  } ppl_ch_state_t;

endpackage

// >>> logic/ppl_top.sv
// Phase pulse limits, transient aids and fault sequencing for a dual-channel controller
//
// Behaviour
// - Pulses stay high at least min on-time unless truncated, braked or shut down
// - Phase stays low at least min off-time
// - Blanking interval between adjacent phase rising edges
// - Pulse rate capped by off-time and blanking
// - Dynamic integrator threshold selects alternate integrator
// - Level one undershoot adds configured extra phases
// - Level two undershoot enables all channel phases
// - Braking tri-states phases, ends by timeout
// - Truncation cuts running pulses on overshoot
// - Unmasked status bit drives alert active
// - Clear command, disable or power cycle clears
// - Channel fault stops one; shared stops both
// - Warnings flag status, never stop conversion
// - Ignored faults act exactly like warnings
// - Latch-off holds until host toggles enable
// - Hysteretic restarts when condition clears, with delay
// - Hiccup waits, retries with delay, forever
// - Latch-off and hiccup restarts choose last or boot target
// - Fault shutdown skips the turn-off delay
// - Shutdown fault drops power good
// - Restart into present fault re-trips at once
// - Overvoltage pulls low, undervoltage tri-states
//
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ppl_top import ppl_pkg::*; #(
  parameter int HICCUP_CYC = HICCUP_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Avalon-MM register slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pulse requests from the control loop
  input wire logic [NPH-1:0] pulse_req,
  // Asynchronous detector levels
  input wire ppl_det_t det_in,
  // Phase pins
  output logic [NPH-1:0] pwm_out,
  output logic [NPH-1:0] pwm_oe,
  output logic [NPH-1:0] phase_on,
  // Channel outputs
  output logic [NCH-1:0] power_good_out,
  output logic [NCH-1:0] integ_alt_sel,
  output logic [NCH-1:0] boot_target_sel,
  output logic alert_n
);

  localparam int DET_W = $bits(ppl_det_t);
  localparam logic [31:0] HIC_LAST = 32'(HICCUP_CYC - 1);
  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

  logic [1:0] rst_q; // Reset release chain
  logic rst_n; // Synchronous copy of reset
  logic [DET_W-1:0] s1, s2, s3, sflt; // Detector synchronisers
  ppl_det_t det; // Filtered detector levels
  ppl_opt_t opt; // assorted_options register
  ppl_pulse_t pcfg; // Pulse limits
  logic [15:0] brake_to; // Braking timeout in cycles
  logic [NPH-1:0] phase_en; // Populated phases
  logic [NPH-1:0] phase_chan; // Channel of each phase
  ppl_counts_t cnts; // Phase counts
  ppl_rsp_t rsp; // Fault responses
  ppl_dly_t dly; // Turn-on/off delays
  logic [NCH*ST_W-1:0] mask; // Alert mask
  logic [NCH*ST_W-1:0] status; // Latched status
  logic wr_take, rd_take; // Accepted bus access
  logic [6:0] tick_cnt; // Microsecond divider
  logic tick; // One-cycle microsecond pulse
  logic [NPH-1:0] pwm_q; // Internal pulse state
  logic [7:0] pcnt [NPH]; // Cycles since last edge
  logic [NPH-1:0] cand, fire, active;
  logic [4:0] limit [NCH]; // Active phase count per channel
  logic [NCH-1:0] conv, braking, trunc_cut, drv_low, fault_st, fire_ch, clr;
  logic [7:0] bl_cnt [NCH]; // Cycles since channel rising edge
  ppl_ch_state_t state [NCH];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Three-flop synchroniser; a change counts once stages two and three agree
  for (genvar b = 0; b < DET_W; b++) begin : g_sync
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1[b] <= 1'b0;
        s2[b] <= 1'b0;
        s3[b] <= 1'b0;
        sflt[b] <= 1'b0;
      end else begin
        s1[b] <= det_in[b];
        s2[b] <= s1[b];
        s3[b] <= s2[b];
        if (s2[b] == s3[b]) begin
          sflt[b] <= s3[b];
        end
      end
    end
  end
  assign det = ppl_det_t'(sflt);

  // Microsecond tick for the turn-on and turn-off delays
  always_ff @(posedge clk) begin
    if (!rst_n || tick_cnt == TICK_LAST) begin
      tick_cnt <= 7'h00;
    end else begin
      tick_cnt <= tick_cnt + 7'h01;
    end
  end
  assign tick = (tick_cnt == TICK_LAST);

  // Bus handshake: one wait cycle, then the access is taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
    end
  end
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && avs_waitrequest;

  // Read data is loaded while waitrequest is still high, so it stands at the taking edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_take) begin
      case (avs_address)
        ADDR_OPTIONS: avs_readdata <= 32'(opt);
        ADDR_PULSE: avs_readdata <= 32'(pcfg);
        ADDR_BRAKE: avs_readdata <= 32'(brake_to);
        ADDR_PHASES: avs_readdata <= 32'({phase_chan, phase_en});
        ADDR_COUNTS: avs_readdata <= 32'(cnts);
        ADDR_RESP: avs_readdata <= 32'(rsp);
        ADDR_DELAY: avs_readdata <= dly;
        ADDR_MASK: avs_readdata <= 32'(mask);
        ADDR_STATUS: avs_readdata <= 32'({braking, power_good_out, status});
        default: avs_readdata <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Configuration writes; the clear register holds nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opt <= '0;
      pcfg <= '0;
      brake_to <= 16'h0000;
      phase_en <= '0;
      phase_chan <= '0;
      cnts <= '0;
      rsp <= '0;
      dly <= '0;
      mask <= '0;
    end else if (wr_take) begin
      case (avs_address)
        ADDR_OPTIONS: opt <= ppl_opt_t'(avs_writedata[$bits(ppl_opt_t)-1:0]);
        ADDR_PULSE: pcfg <= ppl_pulse_t'(avs_writedata[$bits(ppl_pulse_t)-1:0]);
        ADDR_BRAKE: brake_to <= avs_writedata[15:0];
        ADDR_PHASES: {phase_chan, phase_en} <= avs_writedata[2*NPH-1:0];
        ADDR_COUNTS: cnts <= ppl_counts_t'(avs_writedata[$bits(ppl_counts_t)-1:0]);
        ADDR_RESP: rsp <= ppl_rsp_t'(avs_writedata[$bits(ppl_rsp_t)-1:0]);
        ADDR_DELAY: dly <= avs_writedata;
        ADDR_MASK: mask <= avs_writedata[NCH*ST_W-1:0];
        default: ; // Writes elsewhere are dropped
      endcase
    end
  end

  // Active phase count: undershoot levels override the shed count
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      if (det.undershoot_level_two[c]) begin
        limit[c] = ALL_PHASES;
      end else if (det.undershoot_level_one[c]) begin
        limit[c] = {1'b0, cnts.base_count[c]} + {1'b0, cnts.level_one_phase_count[c]};
      end else begin
        limit[c] = {1'b0, cnts.base_count[c]};
      end
    end
  end

  // Rank populated phases within their channel; lower ranks stay active when shedding
  always_comb begin
    logic [4:0] k0;
    logic [4:0] k1;
    k0 = 5'h00;
    k1 = 5'h00;
    active = '0;
    for (int i = 0; i < NPH; i++) begin
      if (phase_en[i] && phase_chan[i]) begin
        active[i] = (k1 < limit[1]);
        k1 = k1 + 5'h01;
      end else if (phase_en[i]) begin
        active[i] = (k0 < limit[0]);
        k0 = k0 + 5'h01;
      end
    end
  end

  // One rising edge per channel per cycle, lowest phase first
  always_comb begin
    fire = '0;
    fire_ch = '0;
    for (int i = 0; i < NPH; i++) begin
      if (cand[i] && !fire_ch[phase_chan[i]]) begin
        fire[i] = 1'b1;
        fire_ch[phase_chan[i]] = 1'b1;
      end
    end
  end

  // Per-phase pulse shaping
  for (genvar g = 0; g < NPH; g++) begin : g_phase
    logic ch; // Channel of this phase
    logic stop; // Forced end of pulse
    assign ch = phase_chan[g];
    // Off-time and blanking gate the next rising edge, which caps the rate
    assign cand[g] = pulse_req[g] && active[g] && conv[ch] && !braking[ch] && !pwm_q[g]
      && pcnt[g] >= pcfg.min_off && bl_cnt[ch] >= pcfg.blank;
    // Truncation and shutdown override the minimum on-time on purpose
    assign stop = trunc_cut[ch] || !conv[ch] || braking[ch];

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pwm_q[g] <= 1'b0;
        pcnt[g] <= CNT8_MAX;
      end else if (pwm_q[g] && (stop || (!pulse_req[g] && pcnt[g] >= pcfg.min_on))) begin
        pwm_q[g] <= 1'b0;
        pcnt[g] <= 8'h01;
      end else if (fire[g]) begin
        pwm_q[g] <= 1'b1;
        pcnt[g] <= 8'h01;
      end else if (pcnt[g] != CNT8_MAX) begin
        pcnt[g] <= pcnt[g] + 8'h01;
      end
    end

    // Pin drive: overvoltage fault pulls low, truncation keeps the pin driven low, other stops float
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pwm_out[g] <= 1'b0;
        pwm_oe[g] <= 1'b0;
        phase_on[g] <= 1'b0;
      end else begin
        pwm_out[g] <= pwm_q[g] && conv[ch] && !braking[ch];
        pwm_oe[g] <= phase_en[g] && ((conv[ch] && !braking[ch])
          || (fault_st[ch] && drv_low[ch]));
        phase_on[g] <= active[g] && conv[ch];
      end
    end

    a_min_on_hold: assert property ($fell(pwm_q[g]) && !$past(stop)
      |-> $past(pcnt[g]) >= $past(pcfg.min_on))
      else $error("pulse ended before minimum on-time");
    a_min_off_gap: assert property ($rose(pwm_q[g]) |-> $past(pcnt[g]) >= $past(pcfg.min_off))
      else $error("pulse fired before minimum off-time");
  end

  // Per-channel sequencing, braking, status and blanking
  for (genvar c = 0; c < NCH; c++) begin : g_chan
    logic ovf, uvf, ocf, shf, flt; // Faults that are not ignored
    logic [1:0] act; // Response of the active fault
    logic [31:0] cnt; // Delay and hiccup counter
    logic [15:0] bcnt; // Braking time
    logic bdone; // Braking ended by timeout or shutdown during this overshoot
    logic os_d; // Overshoot delayed for edge
    logic [ST_W-1:0] set; // Status events this cycle
    logic dis; // Host disables the channel

    assign ovf = det.ov_f[c] && rsp.ov_rsp != RSP_IGNORE;
    assign uvf = det.uv_f[c] && rsp.uv_rsp != RSP_IGNORE;
    assign ocf = det.oc_f[c] && rsp.oc_rsp != RSP_IGNORE;
    assign shf = det.shared_f && rsp.shared_rsp != RSP_IGNORE;
    // Warnings never enter flt, so they cannot stop conversion
    assign flt = ovf || uvf || ocf || shf;
    assign act = ovf ? rsp.ov_rsp : uvf ? rsp.uv_rsp : ocf ? rsp.oc_rsp : rsp.shared_rsp;
    assign conv[c] = (state[c] == CH_RUN) || (state[c] == CH_TOFF);
    assign fault_st[c] = (state[c] == CH_LATCH) || (state[c] == CH_HYST)
      || (state[c] == CH_HICCUP);
    assign trunc_cut[c] = opt.trunc_en && det.overshoot_threshold[c] && !os_d;
    assign dis = wr_take && avs_address == ADDR_OPTIONS && opt.chan_on[c]
      && !avs_writedata[c];
    assign clr[c] = dis || (wr_take && avs_address == ADDR_CLEAR
      && (avs_writedata[7:0] == PAGE_ALL || avs_writedata[7:0] == 8'(c)));
    assign set = {det.uv_w[c], det.ov_w[c], det.shared_f, det.oc_f[c], det.uv_f[c], det.ov_f[c]};

    // Channel sequencer; every fault path bypasses the turn-off delay
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        state[c] <= CH_OFF;
        cnt <= 32'h0000_0000;
        drv_low[c] <= 1'b0;
        boot_target_sel[c] <= 1'b1; // Cold start uses the boot target
      end else begin
        case (state[c])
          CH_OFF: begin
            cnt <= 32'h0000_0000;
            if (opt.chan_on[c]) begin
              state[c] <= CH_TON;
            end
          end
          CH_TON, CH_RUN, CH_TOFF: begin
            if (flt) begin
              // A restart into a standing fault trips again here
              state[c] <= act == RSP_LATCH ? CH_LATCH : act == RSP_HYST ? CH_HYST
                : CH_HICCUP;
              drv_low[c] <= ovf;
              cnt <= 32'h0000_0000;
            end else if (state[c] == CH_TON) begin
              if (!opt.chan_on[c]) begin
                state[c] <= CH_OFF;
              end else if (cnt >= 32'(dly.ton_us)) begin
                state[c] <= CH_RUN;
                cnt <= 32'h0000_0000;
              end else if (tick) begin
                cnt <= cnt + 32'h0000_0001;
              end
            end else if (state[c] == CH_RUN) begin
              if (!opt.chan_on[c]) begin
                state[c] <= CH_TOFF;
              end
            end else if (opt.chan_on[c]) begin
              state[c] <= CH_RUN;
              cnt <= 32'h0000_0000;
            end else if (cnt >= 32'(dly.toff_us)) begin
              state[c] <= CH_OFF;
            end else if (tick) begin
              cnt <= cnt + 32'h0000_0001;
            end
          end
          CH_LATCH: begin
            if (!opt.chan_on[c]) begin
              state[c] <= CH_OFF;
              boot_target_sel[c] <= opt.restart_target_select;
            end
          end
          CH_HYST: begin
            if (!opt.chan_on[c]) begin
              state[c] <= CH_OFF;
            end else if (!flt) begin
              state[c] <= CH_TON;
            end
          end
          CH_HICCUP: begin
            if (!opt.chan_on[c]) begin
              state[c] <= CH_OFF;
            end else if (cnt >= HIC_LAST) begin
              state[c] <= CH_TON;
              cnt <= 32'h0000_0000;
              boot_target_sel[c] <= opt.restart_target_select;
            end else begin
              cnt <= cnt + 32'h0000_0001;
            end
          end
          default: state[c] <= CH_OFF;
        endcase
      end
    end

    // Diode braking, limited per overshoot event by the timeout
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        braking[c] <= 1'b0;
        bcnt <= 16'h0000;
        bdone <= 1'b0;
        os_d <= 1'b0;
      end else begin
        os_d <= det.overshoot_threshold[c];
        if (braking[c]) begin
          if (!det.overshoot_threshold[c] || bcnt >= brake_to || !conv[c]) begin
            braking[c] <= 1'b0;
            bdone <= det.overshoot_threshold[c];
          end else if (bcnt != CNT16_MAX) begin
            bcnt <= bcnt + 16'h0001;
          end
        end else if (opt.brake_en && det.overshoot_threshold[c] && !bdone && conv[c]
          && brake_to != 16'h0000) begin
          braking[c] <= 1'b1;
          bcnt <= 16'h0001;
        end else if (!det.overshoot_threshold[c]) begin
          bdone <= 1'b0;
        end
      end
    end

    // Sticky status; a new event wins over a clear in the same cycle
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        status[c*ST_W +: ST_W] <= '0;
      end else begin
        status[c*ST_W +: ST_W] <= (status[c*ST_W +: ST_W] & ~{ST_W{clr[c]}})
          | set;
      end
    end

    // Blanking counter restarts on any rising edge in the channel
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        bl_cnt[c] <= CNT8_MAX;
      end else if (fire_ch[c]) begin
        bl_cnt[c] <= 8'h01;
      end else if (bl_cnt[c] != CNT8_MAX) begin
        bl_cnt[c] <= bl_cnt[c] + 8'h01;
      end
    end

    // Power good and integrator select
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        power_good_out[c] <= 1'b0;
        integ_alt_sel[c] <= 1'b0;
      end else begin
        power_good_out[c] <= (state[c] == CH_RUN);
        integ_alt_sel[c] <= det.dyn_integ_threshold[c];
      end
    end

    sequence s_fault_hit;
      conv[c] && flt;
    endsequence
    sequence s_shut_down;
      fault_st[c] ##1 !power_good_out[c];
    endsequence
    a_fault_stops_now: assert property (s_fault_hit |=> s_shut_down)
      else $error("fault did not stop channel at once");
    a_blank_space: assert property (fire_ch[c] |-> bl_cnt[c] >= pcfg.blank)
      else $error("rising edges closer than blanking");
    a_brake_limit: assert property (braking[c] |-> bcnt <= brake_to)
      else $error("braking ran past timeout");
    a_latch_hold: assert property (state[c] == CH_LATCH && opt.chan_on[c]
      |=> state[c] == CH_LATCH)
      else $error("latched channel left without disable");
    a_hiccup_wait: assert property (state[c] == CH_HICCUP && opt.chan_on[c] && cnt < HIC_LAST
      |=> state[c] == CH_HICCUP)
      else $error("hiccup retry before wait elapsed");
    a_dint_follow: assert property (det.dyn_integ_threshold[c] |=> integ_alt_sel[c])
      else $error("alternate integrator not selected");
    a_usr_all: assert property (det.undershoot_level_two[c] |-> limit[c] == ALL_PHASES)
      else $error("level two undershoot did not add all phases");
    a_ov_low: assert property (fault_st[c] && drv_low[c] && phase_en[0] && !phase_chan[0]
      && c == 0 |=> pwm_oe[0] && !pwm_out[0])
      else $error("overvoltage did not pull phase low");
  end

  // Alert: any unmasked latched status bit pulls the line active
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= ~|(status & ~mask);
    end
  end

  a_alert_follow: assert property (|(status & ~mask) |=> !alert_n)
    else $error("unmasked status without alert");

endmodule

// >>> sim/ppl_stage_model.sv
// Power stage model: counts the pulses it receives while its pin is driven
`timescale 1ns/1ps
module ppl_stage_model import ppl_pkg::*; (
  // Pins from the supervisor
  input wire logic clk,
  input wire logic [NPH-1:0] pwm_out,
  input wire logic [NPH-1:0] pwm_oe,
  // Pulses seen so far
  output int rises
);
  logic [NPH-1:0] prev = '0; // Driven-high level one cycle ago
  initial rises = 0;
  // A floating pin never turns the high-side on, so only driven highs count
  always @(posedge clk) begin
    prev <= pwm_out & pwm_oe;
    rises <= rises + $countones(pwm_out & pwm_oe & ~prev);
  end
endmodule

// >>> sim/ppl_top_bench.sv
// Random and corner-case bench for the phase pulse supervisor
`timescale 1ns/1ps
module ppl_top_bench;
  import ppl_pkg::*;
  logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0;
  logic [5:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata, rd;
  logic avs_waitrequest, alert_n;
  logic [NPH-1:0] pulse_req = '0, pwm_out, pwm_oe, phase_on, pq = '0;
  logic [NCH-1:0] power_good_out, integ_alt_sel, boot_target_sel;
  ppl_det_t det = '0;
  int err_count = 0, cmp_count = 0, seed = 4, rises, hi[8], lo[8], sb[2];
  logic mon_en = 0; // Pulse checks only while faults cannot cut pulses
  always #4 clk = ~clk;
  ppl_top #(.HICCUP_CYC(50)) dut_u (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pulse_req(pulse_req),
    .det_in(det), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .phase_on(phase_on),
    .power_good_out(power_good_out), .integ_alt_sel(integ_alt_sel),
    .boot_target_sel(boot_target_sel), .alert_n(alert_n));
  ppl_stage_model stage_u (.clk(clk), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .rises(rises));
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      $display("BAD %s exp %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  // Avalon access: hold the request until waitrequest is sampled low
  task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    if (w) avs_write <= 1; else avs_read <= 1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Pulse width, off-time and blanking monitor, limits 6, 5 and 3 cycles as programmed
  always @(posedge clk) begin
    pq <= pwm_out;
    for (int i = 0; i < 8; i++) begin
      if (mon_en && pq[i] && !pwm_out[i]) chk("min_on", hi[i] >= 6, 1);
      if (mon_en && !pq[i] && pwm_out[i]) begin
        chk("min_off", lo[i] >= 5, 1);
        chk("blank", sb[i/4] >= 3, 1);
      end
      hi[i] <= pwm_out[i] ? hi[i] + 1 : 0;
      lo[i] <= pwm_out[i] ? 0 : lo[i] + 1;
    end
    for (int c = 0; c < 2; c++) sb[c] <= (|(pwm_out[c*4+:4] & ~pq[c*4+:4])) ? 1 : sb[c] + 1;
  end
  // Watchdog sized well above the expected run length
  initial begin
    #400000;
    err_count++;
    summarize();
  end
  initial begin
    cyc(16);
    arst_n <= 1;
    cyc(4);
    chk("boot_sel", boot_target_sel, 2'b11);
    acc(0, 6'h3C, 0);
    chk("unmapped", rd, 0);
    acc(1, ADDR_PULSE, 32'h0003_0506);
    acc(1, ADDR_PHASES, 32'h000F_00FF);
    acc(1, ADDR_COUNTS, 32'h0000_0044);
    acc(1, ADDR_RESP, 32'h0000_0001);
    acc(1, ADDR_OPTIONS, 32'h0000_0003);
    for (int k = 0; k < 2000 && power_good_out !== 2'b11; k++) cyc(1);
    chk("phase_on", phase_on, 12'h0FF);
    $display("test start done");
    det.ov_w[0] <= 1;
    cyc(8);
    acc(0, ADDR_STATUS, 0);
    chk("warn", rd[13:0], 14'h3010);
    chk("alert", alert_n, 0);
    det.ov_w[0] <= 0;
    cyc(8);
    acc(0, ADDR_STATUS, 0);
    chk("latched", rd[5:0], 6'h10);
    acc(1, ADDR_CLEAR, 32'h0000_00FF);
    cyc(2);
    acc(0, ADDR_STATUS, 0);
    chk("cleared", {alert_n, rd[11:0]}, 13'h1000);
    acc(1, ADDR_MASK, 32'h0000_0800);
    det.uv_w[1] <= 1;
    cyc(8);
    acc(0, ADDR_STATUS, 0);
    chk("masked", {alert_n, rd[11]}, 2'b11);
    det.uv_w[1] <= 0;
    $display("test status done");
    // Shed to two phases each, then undershoot levels add phases back
    acc(1, ADDR_COUNTS, 32'h0000_1122);
    cyc(2);
    chk("shed", phase_on, 12'h033);
    det.undershoot_level_one[0] <= 1;
    det.dyn_integ_threshold[1] <= 1;
    cyc(8);
    chk("undershoot_level_one", phase_on, 12'h037);
    chk("dint", integ_alt_sel, 2'b10);
    det.undershoot_level_two[1] <= 1;
    cyc(8);
    chk("undershoot_level_two", phase_on, 12'h0F7);
    det.undershoot_level_one[0] <= 0;
    det.undershoot_level_two[1] <= 0;
    det.dyn_integ_threshold[1] <= 0;
    acc(1, ADDR_COUNTS, 32'h0000_0044);
    cyc(8);
    chk("unshed", {integ_alt_sel, phase_on}, 14'h00FF);
    $display("test transient done");
    mon_en <= 1;
    repeat (400) @(posedge clk) pulse_req <= 12'($random(seed));
    pulse_req <= '0;
    cyc(10);
    mon_en <= 0;
    chk("stage", rises > 20, 1);
    $display("test pulses done");
    det.ov_f[0] <= 1;
    cyc(8);
    chk("shut", {power_good_out, pwm_out[3:0], pwm_oe[3:0]}, 10'h20F);
    det.ov_f[0] <= 0;
    cyc(20);
    chk("latch", power_good_out, 2'b10);
    acc(1, ADDR_OPTIONS, 32'h0000_0002);
    acc(1, ADDR_OPTIONS, 32'h0000_0003);
    for (int k = 0; k < 2000 && power_good_out !== 2'b11; k++) cyc(1);
    chk("restart", power_good_out, 2'b11);
    chk("boot_sel2", boot_target_sel, 2'b10);
    $display("test fault done");
    summarize();
  end
endmodule
